/* bench/afm_props.sv */
// assertions on the command bus and drive outputs of the axis fault monitor
`timescale 1ns/1ps
module afm_props (
  input wire logic clk, // system clock
  input wire logic resetn, // reset, active low
  input wire logic cmd_valid, // host offers a command
  input wire logic [2:0] cmd_code, // command code
  input wire logic [23:0] cmd_data0, // first operand
  input wire logic [23:0] cmd_data1, // second operand
  input wire logic cmd_parity, // parity bit
  input wire logic cmd_ack, // good exchange
  input wire logic cmd_err, // faulty exchange
  input wire logic ctrl_fault, // controller fault level
  input wire logic host_fault, // host problem level
  input wire logic [23:0] drive_cmd, // drive command
  input wire logic drive_enable, // drive enable
  input wire logic led_loop_active, // loop indicator
  input wire logic led_activity, // activity indicator
  input wire logic led_link_fault // link-fault indicator
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  logic bad; // odd parity over the offered word
  assign bad = ^{cmd_code, cmd_data0, cmd_data1, cmd_parity};
  // exchange kinds
  sequence good_x; cmd_valid && !bad; endsequence
  sequence bad_x; cmd_valid && bad; endsequence
  sequence engage_x; good_x ##0 (cmd_code == afm_pkg::AFM_CMD_ENGAGE); endsequence
  a_ack_on_good: assert property (good_x |-> cmd_ack && !cmd_err)
    else $error("good command not acknowledged");
  a_err_on_bad: assert property (bad_x |-> cmd_err && !cmd_ack)
    else $error("bad parity not refused");
  a_answer_needs_offer: assert property ((cmd_ack || cmd_err) |-> cmd_valid)
    else $error("answer without an offer");
  a_offer_single: assert property (cmd_valid |=> !cmd_valid)
    else $error("offer longer than one cycle");
  a_activity_shows: assert property (cmd_valid |-> ##[1:2] led_activity)
    else $error("activity indicator missed an exchange");
  a_link_fault_sets: assert property (bad_x |-> ##[1:2] led_link_fault)
    else $error("link fault not lit");
  a_link_fault_clears: assert property (
    good_x ##0 (!ctrl_fault && !host_fault) |-> ##[1:2] !led_link_fault)
    else $error("link fault not cleared");
  a_loop_led_drive: assert property (led_loop_active |-> drive_enable)
    else $error("loop indicator without drive enable");
  a_zero_when_off: assert property (!drive_enable |-> drive_cmd == afm_pkg::DRIVE_ZERO)
    else $error("drive command not zero while disabled");
  a_engage_drives: assert property (
    engage_x |-> ##[1:3] (drive_enable && led_loop_active))
    else $error("engage did not enable the loop");
endmodule // afm_props

/* bench/axis_fault_monitor_status_bench.sv */
// self-checking bench: host end and device joined by the command bus
`timescale 1ns/1ps
module axis_fault_monitor_status_bench;
  localparam int SAMP = 100; // shortened sample period
  logic clk = 1'b0; // system clock
  logic resetn = 1'b0; // reset, active low
  logic req_valid = 1'b0; // request strobe
  logic [2:0] req_code = 3'h0; // request code
  logic [23:0] req_data0 = 24'h000000; // first operand
  logic [23:0] req_data1 = 24'h000000; // second operand
  logic req_corrupt = 1'b0; // parity fault injection
  logic enc_one = 1'b0; // encoder channel one
  logic enc_two = 1'b0; // encoder channel two
  logic st_pass = 1'b1; // self test result
  logic st_done_in = 1'b0; // self test finished
  logic ctrl_fault = 1'b0; // controller fault level
  logic host_fault = 1'b0; // host problem level
  logic req_ready, done, done_err, drive_enable; // single-bit outputs
  logic led_loop_active, led_self_test, led_activity, led_link_fault, led_fault; // indicators
  logic [23:0] drive_cmd, position; // device words
  logic [23:0] exp_pos = 24'h000000; // expected position count
  int err_count = 0; // mismatches
  int samples_checked = 0; // comparisons
  int cycles = 0; // run length
  afm_if bus_if();
  afm_device #(.SAMPLE_CYC(SAMP), .BLINK_CYC(8), .ACT_CYC(4)) afm_device_i (.clk(clk),
    .resetn(resetn), .bus(bus_if.dev), .encoder_channel_one(enc_one),
    .encoder_channel_two(enc_two), .self_test_done(st_done_in), .self_test_pass(st_pass),
    .ctrl_fault(ctrl_fault), .host_fault(host_fault), .drive_cmd(drive_cmd),
    .drive_enable(drive_enable), .position(position), .led_loop_active(led_loop_active),
    .led_self_test(led_self_test), .led_activity(led_activity),
    .led_link_fault(led_link_fault), .led_fault(led_fault));
  afm_host afm_host_i (.clk(clk), .resetn(resetn), .bus(bus_if.host), .req_valid(req_valid),
    .req_code(req_code), .req_data0(req_data0), .req_data1(req_data1),
    .req_corrupt(req_corrupt), .req_ready(req_ready), .done(done), .done_err(done_err));
  afm_props afm_props_i (.clk(clk), .resetn(resetn), .cmd_valid(bus_if.cmd_valid),
    .cmd_code(bus_if.cmd_code), .cmd_data0(bus_if.cmd_data0), .cmd_data1(bus_if.cmd_data1),
    .cmd_parity(bus_if.cmd_parity), .cmd_ack(bus_if.cmd_ack), .cmd_err(bus_if.cmd_err),
    .ctrl_fault(ctrl_fault), .host_fault(host_fault), .drive_cmd(drive_cmd),
    .drive_enable(drive_enable), .led_loop_active(led_loop_active),
    .led_activity(led_activity), .led_link_fault(led_link_fault));
  // free-running clock, 8 ns period
  initial forever #4 clk = ~clk;
  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      err_count++;
      give_verdict();
    end
  end
  // compare one value
  task automatic check(string what, logic [23:0] seen, logic [23:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  // counts, verdict, end of run
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // one command through the host end, error flag judged against the parity fault
  task automatic send(afm_pkg::afm_cmd_type code, logic [23:0] d0, logic [23:0] d1, logic bad);
    int n;
    @(negedge clk);
    {req_valid, req_code, req_data0, req_data1, req_corrupt} = {1'b1, code, d0, d1, bad};
    check("req_ready", req_ready, 1);
    @(negedge clk);
    req_valid = 1'b0;
    for (n = 0; n < 4 && done !== 1'b1; n++) @(negedge clk);
    check("done", done, 1);
    check("done_err", done_err, bad);
  endtask
  // quarter steps of the encoder; channel one leads when clockwise
  task automatic turn(int n, bit cw);
    repeat (n) begin
      repeat (4) @(negedge clk);
      if ((enc_one == enc_two) == cw) enc_one = ~enc_one;
      else enc_two = ~enc_two;
      exp_pos = cw ? exp_pos + 24'h1 : exp_pos - 24'h1;
    end
    repeat (6) @(negedge clk);
  endtask
  // hold the error at the limit, then one count beyond it
  task automatic trip_at(int lim);
    turn(lim, 1);
    repeat (2 * SAMP) @(negedge clk);
    check("enable at limit", drive_enable, 1);
    check("drive_cmd", drive_cmd, 24'(-lim));
    turn(1, 1);
    repeat (SAMP + 4) @(negedge clk);
    check("enable tripped", drive_enable, 0);
    check("drive zeroed", drive_cmd, 0);
    check("fault steady", led_fault, 1);
    check("loop led off", led_loop_active, 0);
    repeat (2 * SAMP) @(negedge clk);
    check("trip latched", drive_enable, 0);
  endtask
  // engage the loop and optionally command a move at the present count
  task automatic engage(logic moving);
    send(afm_pkg::AFM_CMD_ENGAGE, 24'h000000, 24'h000000, 0);
    send(afm_pkg::AFM_CMD_POS, exp_pos, {23'h000000, moving}, 0);
    repeat (3) @(negedge clk);
    check("engaged", drive_enable, 1);
    check("loop led on", led_loop_active, 1);
    check("fault cleared", led_fault, 0);
  endtask
  // indicators after a passing self test, then decode both ways across zero
  task automatic t_start_decode();
    check("self test pending", led_self_test, 0);
    st_done_in = 1'b1;
    repeat (2) @(negedge clk);
    check("self test led", led_self_test, 1);
    check("idle enable", drive_enable, 0);
    turn(10, 1);
    check("position cw", position, exp_pos);
    turn(13, 0);
    check("position wrap", position, 24'hfffffd);
    $display("test start_decode finished");
  endtask
  // faulty then good exchange, activity pulse, refused engage
  task automatic t_link();
    send(afm_pkg::AFM_CMD_ENGAGE, 24'h000000, 24'h000000, 1);
    check("link fault on", led_link_fault, 1);
    check("activity", led_activity, 1);
    check("refused engage", drive_enable, 0);
    repeat (10) @(negedge clk);
    check("activity off", led_activity, 0);
    send(afm_pkg::AFM_CMD_NOP, 24'h000000, 24'h000000, 0);
    check("link fault off", led_link_fault, 0);
    $display("test link finished");
  endtask
  // default idle and moving limits, host limits, then a plain disengage
  task automatic t_trips();
    engage(0);
    trip_at(193);
    engage(1);
    trip_at(2048);
    send(afm_pkg::AFM_CMD_COMP, 24'h000005, 24'h000014, 0);
    engage(0);
    trip_at(5);
    engage(1);
    trip_at(20);
    engage(0);
    send(afm_pkg::AFM_CMD_DISENGAGE, 24'h000000, 24'h000000, 0);
    repeat (4) @(negedge clk);
    check("disengaged", drive_enable, 0);
    check("no fault", led_fault, 0);
    $display("test trips finished");
  endtask
  // controller fault blinks, host problem lights link fault
  task automatic t_faults();
    logic a;
    ctrl_fault = 1'b1;
    repeat (6) @(negedge clk);
    a = led_fault;
    repeat (8) @(negedge clk);
    check("fault blink", led_fault ^ a, 1);
    check("link on ctrl", led_link_fault, 1);
    ctrl_fault = 1'b0;
    host_fault = 1'b1;
    repeat (6) @(negedge clk);
    check("link on host", led_link_fault, 1);
    host_fault = 1'b0;
    repeat (10) @(negedge clk);
    send(afm_pkg::AFM_CMD_NOP, 24'h000000, 24'h000000, 0);
    check("link recovered", led_link_fault, 0);
    $display("test faults finished");
  endtask
  // failed self test lights four indicators together
  task automatic t_startup_fault();
    resetn = 1'b0;
    st_pass = 1'b0;
    repeat (3) @(negedge clk);
    resetn = 1'b1;
    repeat (6) @(negedge clk);
    check("four leds", {led_self_test, led_activity, led_link_fault, led_fault}, 4'hf);
    $display("test startup_fault finished");
  endtask
  // main sequence
  initial begin
    repeat (12) @(negedge clk);
    resetn = 1'b1;
    t_start_decode();
    t_link();
    t_trips();
    t_faults();
    t_startup_fault();
    give_verdict();
  end
endmodule // axis_fault_monitor_status_bench

/* design/afm_device.sv */
// axis fault monitor: quadrature decode, following-error trip, status indicators
`timescale 1ns/1ps
module afm_device #(
  parameter int SAMPLE_CYC = afm_pkg::SAMPLE_CYCLES, // cycles per loop sample
  parameter int BLINK_CYC = afm_pkg::BLINK_CYCLES, // half period of fault blink
  parameter int ACT_CYC = afm_pkg::ACT_CYCLES // activity indicator stretch
) (
  input wire logic clk, // system clock
  input wire logic resetn, // asynchronous reset, active low
  afm_if.dev bus, // host command bus
  input wire logic encoder_channel_one, // encoder channel one pin
  input wire logic encoder_channel_two, // encoder channel two pin
  input wire logic self_test_done, // power-up self test finished
  input wire logic self_test_pass, // self test result
  input wire logic ctrl_fault, // internal controller fault level
  input wire logic host_fault, // host processor problem level
  output logic [23:0] drive_cmd, // drive command, zero when off
  output logic drive_enable, // drive enable output
  output logic [23:0] position, // actual encoder position
  output logic led_loop_active, // loop-active indicator
  output logic led_self_test, // self-test-pass indicator
  output logic led_activity, // host-activity indicator
  output logic led_link_fault, // link-fault indicator
  output logic led_fault // fault indicator
);
  // synchronisers for encoder pins and outside levels
  logic [1:0] s1_a, s1_b, s1_cf, s1_hf;
  logic a_q, b_q; // previous synced channel levels
  logic [2:0] dec_fill; // decode held off until sync and history are loaded
  logic [23:0] cmd_pos; // commanded position from host
  logic moving; // host says motion is being commanded
  logic [23:0] idle_limit; // idle trip limit, counts
  logic [23:0] move_limit; // moving trip limit, counts
  afm_pkg::afm_state_type state; // loop state
  logic trip_seen; // a following-error trip has happened
  logic [31:0] sample_cnt; // loop sample divider
  logic sample_tick; // one-cycle loop sample strobe
  logic [31:0] blink_cnt; // blink divider
  logic blink; // blink phase
  logic [31:0] act_cnt; // activity stretch counter
  logic link_err; // last exchange was faulty
  logic st_done, st_ok; // latched self test result
  logic good_cmd, bad_cmd; // exchange checked this cycle
  logic [23:0] err_abs; // magnitude of following error

  // absolute difference of two 24-bit positions, wrapping
  function automatic logic [23:0] abs_diff(input logic [23:0] x, input logic [23:0] y);
    logic [23:0] d;
    d = x - y;
    return d[23] ? 24'(~d + 24'h000001) : d;
  endfunction

  // exchange parity check
  assign good_cmd = bus.cmd_valid & ~(^{bus.cmd_code, bus.cmd_data0, bus.cmd_data1,
    bus.cmd_parity});
  assign bad_cmd = bus.cmd_valid & ~good_cmd;
  assign bus.cmd_ack = good_cmd; // every offer is answered the same cycle
  assign bus.cmd_err = bad_cmd;

  // two-stage synchronisers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1_a <= 2'b00;
      s1_b <= 2'b00;
      s1_cf <= 2'b00;
      s1_hf <= 2'b00;
    end else begin
      s1_a <= {s1_a[0], encoder_channel_one};
      s1_b <= {s1_b[0], encoder_channel_two};
      s1_cf <= {s1_cf[0], ctrl_fault};
      s1_hf <= {s1_hf[0], host_fault};
    end
  end

  // four-times quadrature decode; 125 MHz samples far above 400 kHz edges
  // a pin resting high after reset must not count as an edge, so wait for history
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      a_q <= 1'b0;
      b_q <= 1'b0;
      dec_fill <= 3'b000;
      position <= 24'h000000;
    end else begin
      a_q <= s1_a[1];
      b_q <= s1_b[1];
      dec_fill <= {dec_fill[1:0], 1'b1}; // fills in three edges after reset
      if (dec_fill[2] && ((s1_a[1] ^ a_q) ^ (s1_b[1] ^ b_q))) begin // one edge
        // channel one leading gives new a equal old b reversed: count up
        if (s1_a[1] ^ b_q) begin
          position <= position + 24'h000001; // clockwise
        end else begin
          position <= position - 24'h000001; // counter-clockwise
        end
      end
    end
  end

  // host commands: position, motion flag, limits
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cmd_pos <= 24'h000000;
      moving <= 1'b0;
      idle_limit <= afm_pkg::IDLE_LIMIT_RST;
      move_limit <= afm_pkg::MOVE_LIMIT_RST;
    end else if (good_cmd) begin
      if (bus.cmd_code == afm_pkg::AFM_CMD_COMP) begin
        idle_limit <= bus.cmd_data0;
        move_limit <= bus.cmd_data1;
      end else if (bus.cmd_code == afm_pkg::AFM_CMD_POS) begin
        cmd_pos <= bus.cmd_data0; // commanded position
        moving <= bus.cmd_data1[0]; // motion flag
      end else if (bus.cmd_code == afm_pkg::AFM_CMD_ENGAGE) begin
        cmd_pos <= position; // engage with zero error
      end
    end
  end

  // 1 kHz sample strobe
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sample_cnt <= 32'h00000000;
      sample_tick <= 1'b0;
    end else begin
      sample_tick <= (sample_cnt == 32'(SAMPLE_CYC - 1));
      sample_cnt <= (sample_cnt == 32'(SAMPLE_CYC - 1)) ? 32'h00000000 : sample_cnt + 32'h1;
    end
  end

  assign err_abs = abs_diff(position, cmd_pos);

  // loop state: engage, sample check, zero then disable, latched trip
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= afm_pkg::AFM_ST_OFF;
      trip_seen <= 1'b0;
    end else begin
      case (state)
        afm_pkg::AFM_ST_ON: begin
          if (good_cmd && bus.cmd_code == afm_pkg::AFM_CMD_DISENGAGE) begin
            state <= afm_pkg::AFM_ST_OFF;
          end else if (sample_tick && (moving ? err_abs > move_limit
              : err_abs > idle_limit)) begin
            state <= afm_pkg::AFM_ST_ZERO; // zero the drive first
            trip_seen <= 1'b1;
          end
        end
        afm_pkg::AFM_ST_ZERO: begin
          state <= afm_pkg::AFM_ST_TRIP; // then drop enable
        end
        default: begin // off or tripped: only engage restarts
          if (good_cmd && bus.cmd_code == afm_pkg::AFM_CMD_ENGAGE) begin
            state <= afm_pkg::AFM_ST_ON;
            trip_seen <= 1'b0;
          end
        end
      endcase
    end
  end

  // drive outputs from flip-flops
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      drive_cmd <= afm_pkg::DRIVE_ZERO;
      drive_enable <= 1'b0;
    end else begin
      drive_enable <= (state == afm_pkg::AFM_ST_ON) || (state == afm_pkg::AFM_ST_ZERO);
      drive_cmd <= (state == afm_pkg::AFM_ST_ON) ? 24'(cmd_pos - position)
                 : afm_pkg::DRIVE_ZERO;
    end
  end
  // loop indicator only while running with enable up; drops at once on disengage or trip
  assign led_loop_active = drive_enable && (state == afm_pkg::AFM_ST_ON);

  // self test result latch
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_done <= 1'b0;
      st_ok <= 1'b0;
    end else if (self_test_done && !st_done) begin
      st_done <= 1'b1;
      st_ok <= self_test_pass;
    end
  end

  // link error flag: set on bad exchange, cleared by good one
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      link_err <= 1'b0;
    end else if (bad_cmd) begin
      link_err <= 1'b1;
    end else if (good_cmd) begin
      link_err <= 1'b0;
    end
  end

  // activity stretch and blink dividers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      act_cnt <= 32'h00000000;
      blink_cnt <= 32'h00000000;
      blink <= 1'b0;
    end else begin
      if (bus.cmd_valid) begin
        act_cnt <= 32'(ACT_CYC); // restart pulse on each exchange
      end else if (act_cnt != 32'h00000000) begin
        act_cnt <= act_cnt - 32'h1;
      end
      if (blink_cnt == 32'(BLINK_CYC - 1)) begin
        blink_cnt <= 32'h00000000;
        blink <= ~blink;
      end else begin
        blink_cnt <= blink_cnt + 32'h1;
      end
    end
  end

  // indicator outputs; failed self test lights four together
  always_comb begin
    if (st_done && !st_ok) begin
      led_self_test = 1'b1;
      led_activity = 1'b1;
      led_link_fault = 1'b1;
      led_fault = 1'b1;
    end else begin
      led_self_test = st_ok;
      led_activity = (act_cnt != 32'h00000000);
      led_link_fault = link_err | s1_hf[1] | s1_cf[1];
      if (s1_cf[1]) begin
        led_fault = blink;
      end else begin
        led_fault = trip_seen;
      end
    end
  end
endmodule // afm_device

/* design/afm_host.sv */
// host end: turns user requests into parity-protected command bus offers
`timescale 1ns/1ps
module afm_host (
  input wire logic clk, // system clock
  input wire logic resetn, // asynchronous reset, active low
  afm_if.host bus, // command bus to device
  input wire logic req_valid, // user offers a command
  input wire logic [2:0] req_code, // command code
  input wire logic [23:0] req_data0, // first operand
  input wire logic [23:0] req_data1, // second operand
  input wire logic req_corrupt, // flip parity for fault injection
  output logic req_ready, // host can take a request
  output logic done, // one-cycle pulse, exchange answered
  output logic done_err // device reported faulty exchange
);
  logic busy; // command held on the bus
  // hold a command for one cycle, device answers in that cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busy <= 1'b0;
      bus.cmd_code <= 3'b000;
      bus.cmd_data0 <= 24'h000000;
      bus.cmd_data1 <= 24'h000000;
      bus.cmd_parity <= 1'b0;
      done <= 1'b0;
      done_err <= 1'b0;
    end else begin
      done <= busy;
      done_err <= busy & bus.cmd_err;
      if (busy) begin
        busy <= 1'b0;
      end else if (req_valid) begin
        busy <= 1'b1;
        bus.cmd_code <= req_code;
        bus.cmd_data0 <= req_data0;
        bus.cmd_data1 <= req_data1;
        bus.cmd_parity <= (^{req_code, req_data0, req_data1}) ^ req_corrupt;
      end
    end
  end
  assign bus.cmd_valid = busy;
  assign req_ready = ~busy;
endmodule // afm_host

/* design/afm_if.sv */
// command bus between host processor and axis fault monitor
`timescale 1ns/1ps
interface afm_if;
  logic cmd_valid; // host offers a command
  logic [2:0] cmd_code; // command code
  logic [23:0] cmd_data0; // first operand
  logic [23:0] cmd_data1; // second operand
  logic cmd_parity; // even parity over code and operands
  logic cmd_ack; // device took the command
  logic cmd_err; // device found the command faulty
  modport dev (input cmd_valid, input cmd_code, input cmd_data0, input cmd_data1,
    input cmd_parity, output cmd_ack, output cmd_err);
  modport host (output cmd_valid, output cmd_code, output cmd_data0, output cmd_data1,
    output cmd_parity, input cmd_ack, input cmd_err);
endinterface

/* design/afm_pkg.sv */
// shared constants and types for the axis fault monitor and its host end
package afm_pkg;
  localparam int POS_W = 24;                       // position width
  localparam int CLK_HZ = 125000000;               // system clock rate
  localparam int SAMPLE_HZ = 1000;                 // loop sample rate
  localparam int SAMPLE_CYCLES = CLK_HZ / SAMPLE_HZ; // cycles per sample
  localparam int COUNTS_PER_REV = 4096;            // decoded counts per turn
  localparam int IDLE_DEG = 17;                    // idle trip angle
  localparam int MOVE_DEG = 180;                   // moving trip angle
  localparam logic [23:0] IDLE_LIMIT_RST = 24'(IDLE_DEG * COUNTS_PER_REV / 360);
  localparam logic [23:0] MOVE_LIMIT_RST = 24'(MOVE_DEG * COUNTS_PER_REV / 360);
  localparam logic [23:0] DRIVE_ZERO = 24'h000000; // zero drive command
  localparam int BLINK_HZ = 4;                     // fault blink rate
  localparam int BLINK_CYCLES = CLK_HZ / (2 * BLINK_HZ); // half period
  localparam int ACT_CYCLES = 1250000;             // activity stretch, 10 ms
  // host command codes
  typedef enum logic [2:0] {
    AFM_CMD_NOP = 3'b000,
    AFM_CMD_ENGAGE = 3'b001,
    AFM_CMD_DISENGAGE = 3'b010,
    AFM_CMD_COMP = 3'b011,
    AFM_CMD_POS = 3'b100
  } afm_cmd_type;
  // loop states
  typedef enum logic [1:0] {
    AFM_ST_OFF = 2'b00,
    AFM_ST_ZERO = 2'b01,
    AFM_ST_ON = 2'b10,
    AFM_ST_TRIP = 2'b11
  } afm_state_type;
endpackage
